//--- bench/pad_board.sv
// Purpose: board side of the eight pins
// Assumes: no pull on any pin
// Notes: a released pin follows the bench's changing level, never the last driven one
`default_nettype none
module pad_board
(
	input wire logic [7:0] pad_out_i,
	input wire logic [7:0] pad_oe_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] wire_o
);
	timeunit 1ns;
	timeprecision 1ns;
	assign wire_o = (pad_out_i & pad_oe_i) | (ext_i & ~pad_oe_i);
endmodule
`default_nettype wire

//--- bench/port_a_props.sv
// Purpose: concurrent checks on the port's bus answer and pin controls
// Assumes: ack one cycle after a taken request
// Notes: release check runs outside the reset disable
`default_nettype none
module port_a_props
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [7:0] pad_in_i,
	input wire logic [7:0] pad_oe_o,
	input wire logic instr_clock_out_o,
	input wire logic [4:0] analog_sel_o,
	input wire logic [7:0] schmitt_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);
	sequence quarter_s;
		instr_clock_out_o ##1 !instr_clock_out_o [*2] ##1 instr_clock_out_o;
	endsequence
	sequence rd_s(logic [7:0] ix);
		wb_ack_o && !wb_we_i && wb_adr_i[9:2] == ix;
	endsequence
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_read_pins: assert property (rd_s(gpio_pkg::REG_DATA_IDX) |->
		wb_dat_o == {24'h0, $past(pad_in_i) & ~{3'h0, $past(analog_sel_o)}})
		else $error("data read differs from pin levels");
	a_dir_five: assert property (rd_s(gpio_pkg::REG_DIR_IDX) |-> wb_dat_o[5])
		else $error("direction bit five read as zero");
	a_pin5_input: assert property (pad_oe_o[5] == 1'b0)
		else $error("pin five driven");
	a_analog_off: assert property ((pad_oe_o[4:0] & analog_sel_o) == 5'h00)
		else $error("analog pin driven");
	a_buffers: assert property (schmitt_sel_o[6:0] == 7'h70)
		else $error("wrong input buffer kind");
	a_quarter_clk: assert property ($rose(instr_clock_out_o) |=> quarter_s)
		else $error("instruction clock not a quarter rate");
	a_release_idle: assert property (disable iff (1'b0) $fell(por_i) && !rst_i |->
		pad_oe_o == 8'h00 && analog_sel_o == 5'h1f)
		else $error("pins not idle after power-on reset");
endmodule
bind port_a_gpio port_a_props i_props (.clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pad_in_i, .pad_oe_o, .instr_clock_out_o,
	.analog_sel_o, .schmitt_sel_o);
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench for the port
// Assumes: reads are compared when their ack arrives
// Notes: board level changes only between bus cycles
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, rst_i, por_i, cyc, stb, we, od, ack, tck, mck, ock, ick;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [7:0] ext, pin, pout, poe, sch, r, d;
	logic [4:0] asel;
	logic [31:0] q[$];
	int mismatches, n_tests, seed, i;
	port_a_gpio i_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
		.osc_drive_i(od), .timer_zero_ext_clock_o(tck), .master_clear_in_o(mck),
		.oscillator_input_o(ock), .instr_clock_out_o(ick), .analog_sel_o(asel),
		.schmitt_sel_o(sch));
	pad_board i_pads (.pad_out_i(pout), .pad_oe_i(poe), .ext_i(ext), .wire_o(pin));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] dv, input logic s);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		sel <= {3'h0, s};
		wdat <= {24'h0, dv};
		n = 0;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
		begin
			mismatches++;
			test_done;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ix, input logic [7:0] e);
		q.push_back({24'h0, e});
		bus(1'b0, ix, 8'h00, 1'b1);
	endtask
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
			chk("rdata", rdat, q.pop_front());
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial
	begin
		seed = 32'h5cad02f5;
		{rst_i, por_i, cyc, stb, we, od} = 6'h30;
		{adr, sel, wdat, ext} = '0;
		mismatches = 0;
		n_tests = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		ext <= 8'hff;
		rd(gpio_pkg::REG_DIR_IDX, 8'hff);
		rd(gpio_pkg::REG_DATA_IDX, 8'he0);
		rd(8'h33, 8'h00);
		for (i = 0; i < 16; i++)
		begin
			bus(1'b1, gpio_pkg::REG_ACFG_IDX, i[7:0], 1'b1);
			@(negedge clk_i);
			chk("asel", asel, i == 0 ? 5'h1f : (i == 6 || i == 7) ? 5'h00 : 5'h0f);
		end
		bus(1'b1, gpio_pkg::REG_ACFG_IDX, 8'h06, 1'b1);
		bus(1'b1, gpio_pkg::REG_DIR_IDX, 8'h00, 1'b1);
		rd(gpio_pkg::REG_DIR_IDX, 8'h20);
		@(negedge clk_i);
		chk("oe", poe, 8'hdf);
		for (i = 0; i < 8; i++)
		begin
			r = 8'($random(seed));
			d = 8'($random(seed));
			@(posedge clk_i);
			ext <= r;
			od <= r[0];
			bus(1'b1, gpio_pkg::REG_DATA_IDX, d, 1'b1);
			@(negedge clk_i);
			chk("pout", pout, d);
			rd(gpio_pkg::REG_DATA_IDX, (d & 8'hdf) | (r & 8'h20));
			bus(1'b1, gpio_pkg::REG_DATA_IDX, ~d, 1'b0);
			@(negedge clk_i);
			chk("rmw", pout, (d & 8'hdf) | (r & 8'h20));
		end
		@(posedge clk_i);
		ext <= 8'hff;
		bus(1'b1, gpio_pkg::REG_FCTL_IDX, 8'h1f, 1'b1);
		repeat (2) @(negedge clk_i);
		chk("owned", poe & 8'h90, 8'h00);
		chk("fn", {sch[7], tck, mck, ock}, 4'hf);
		bus(1'b1, gpio_pkg::REG_FCTL_IDX, 8'h08, 1'b1);
		for (i = 0; i < 2; i++)
		begin
			@(posedge clk_i);
			od <= i[0];
			@(negedge clk_i);
			chk("oscout", {poe[6], pout[6]}, {1'b1, i[0]});
		end
		bus(1'b1, gpio_pkg::REG_FCTL_IDX, 8'h00, 1'b1);
		@(negedge clk_i);
		chk("gate", {sch[7], tck, mck, ock}, 4'h0);
		bus(1'b1, gpio_pkg::REG_DATA_IDX, 8'hff, 1'b1);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("warm", {pout, poe}, 16'he000);
		@(posedge clk_i);
		por_i <= 1'b1;
		@(posedge clk_i);
		por_i <= 1'b0;
		@(negedge clk_i);
		chk("cold", pout, 8'h00);
		test_done;
	end
endmodule
`default_nettype wire

//--- core/gpio_pkg.sv
// Purpose: constants and state layout for the eight-pin general purpose port
// Assumes: register index times four gives the wishbone byte address
// Notes: bus data is 32 bits, registers sit in the low byte
`default_nettype none
package gpio_pkg;
	localparam int PORT_W = 8;
	localparam int IDX_W = 8;
	localparam int ADR_W = 10;
	localparam logic [7:0] REG_DATA_IDX = 8'h05;
	localparam logic [7:0] REG_DIR_IDX = 8'h85;
	localparam logic [7:0] REG_ACFG_IDX = 8'h9f;
	localparam logic [7:0] REG_FCTL_IDX = 8'h40;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [7:0] ACFG_RST = 8'h00;
	localparam logic [7:0] FCTL_RST = 8'h00;
	localparam logic [7:0] ACFG_MASK = 8'hcf;
	localparam logic [7:0] FCTL_MASK = 8'h1f;
	localparam logic [7:0] LATCH_LOW_MASK = 8'h1f;
	localparam int PIN_TMR = 4;
	localparam int PIN_MASTER_CLEAR_IN = 5;
	localparam int PIN_OSC_OUT = 6;
	localparam int PIN_OSC_IN = 7;
	localparam int FCTL_TMR_CLK = 0;
	localparam int FCTL_MASTER_CLEAR_IN = 1;
	localparam int FCTL_OSC_IN = 2;
	localparam int FCTL_OSC_OUT = 3;
	localparam int FCTL_RC_MODE = 4;
	localparam logic [3:0] PCFG_ALL_ANALOG = 4'h0;
	localparam logic [3:0] PCFG_DIGITAL_A = 4'h6;
	localparam logic [3:0] PCFG_DIGITAL_B = 4'h7;
	localparam logic [4:0] ANALOG_ALL = 5'h1f;
	localparam logic [4:0] ANALOG_LOW4 = 5'h0f;
	localparam logic [4:0] ANALOG_NONE = 5'h00;
	localparam logic [7:0] SCHMITT_FIXED = 8'h70;
	localparam logic [1:0] DIV_LAST = 2'h3;

	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
		logic [7:0] acfg;
		logic [7:0] fctl;
		logic ack;
		logic [7:0] rdat;
		logic [1:0] div;
		logic iclk;
	} port_state_t;
endpackage
`default_nettype wire

//--- core/port_a_gpio.sv
// Purpose: eight-pin bidirectional port with direction, analog and pin-function control
// Assumes: classic wishbone slave, pins synchronous to clk_i, one cycle to ack
// Notes: rst_i is a warm reset, por_i marks power-on or brown-out
// Contract
// RULE1: eight two-way pins, each with a data bit and a direction bit.
// RULE2: direction bit one makes the pin an input, driver off.
// RULE3: direction bit zero drives the output latch onto the pin.
// RULE4: data reads return pin levels; data writes go to the latch only.
// RULE5: every data write samples pins, modifies addressed bits, stores into latch.
// RULE6: an enabled peripheral function takes its pin away from general use.
// RULE7: pin five is input only; its direction bit always reads one.
// RULE8: pin four feeds the timer zero clock and analog, schmitt input, push-pull.
// RULE9: pin five feeds master clear and programming voltage, schmitt input.
// RULE10: pins six and seven serve oscillator output and input, push-pull.
// RULE11: pins three to zero are analog inputs, three and two references, ttl.
// RULE12: in rc mode pin six may output a quarter-rate instruction clock.
// RULE13: pin seven buffer is schmitt in rc mode, cmos otherwise.
// RULE14: power-on clears all latch bits; other resets clear low five; direction ones.
// RULE15: software writes 0x06 to analog config and all-ones direction for digital.
// RULE16: pins set analog read back zero from the data register.
// RULE17: driver enabled only with direction zero and no function owning the pin; here pin six drives whenever rc mode or oscillator output owns it.
`default_nettype none
module port_a_gpio
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] pad_in_i,
	output logic [7:0] pad_out_o,
	output logic [7:0] pad_oe_o,
	input wire logic osc_drive_i,
	output logic timer_zero_ext_clock_o,
	output logic master_clear_in_o,
	output logic oscillator_input_o,
	output logic instr_clock_out_o,
	output logic [4:0] analog_sel_o,
	output logic [7:0] schmitt_sel_o
);
	gpio_pkg::port_state_t st_r;
	gpio_pkg::port_state_t st_nxt;
	logic [4:0] analog_mask;
	logic [7:0] analog_pins;
	logic [7:0] taken;
	logic [7:0] pin_read;
	logic [7:0] rd_val;
	logic [7:0] idx;
	logic req;
	logic rc_mode;
	logic wr_take;
	logic wr_lane;
	logic fn_tmr;
	logic fn_master_clear_in;
	logic fn_osc_in;
	logic fn_osc_out;

	// decode of the pin configuration field into the analog pin set
	function automatic logic [4:0] analog_decode(input logic [3:0] pcfg);
		logic [4:0] m;
		m = gpio_pkg::ANALOG_LOW4;
		if (pcfg == gpio_pkg::PCFG_ALL_ANALOG)
		begin
			m = gpio_pkg::ANALOG_ALL;
		end
		else if (pcfg == gpio_pkg::PCFG_DIGITAL_A || pcfg == gpio_pkg::PCFG_DIGITAL_B)
		begin
			m = gpio_pkg::ANALOG_NONE;
		end
		return m;
	endfunction

	// bit five has no driver, so its direction bit is pinned to one on write and read
	function automatic logic [7:0] dir_readback(input logic [7:0] d);
		logic [7:0] v;
		v = d;
		v[gpio_pkg::PIN_MASTER_CLEAR_IN] = 1'b1; // see RULE7
		return v;
	endfunction

	// a disabled function sees a quiet low instead of a toggling pin
	function automatic logic fn_gate(input logic en, input logic lvl);
		return en & lvl;
	endfunction

	// pins owned by a function other than general i/o; analog pins count as owned
	function automatic logic [7:0] owned_pins(input logic [4:0] amask,
		input logic [7:0] fctl, input logic rc);
		logic [7:0] t;
		t = {3'h0, amask}; // see RULE6
		t[gpio_pkg::PIN_TMR] = amask[gpio_pkg::PIN_TMR]
			| fctl[gpio_pkg::FCTL_TMR_CLK]; // see RULE8
		t[gpio_pkg::PIN_MASTER_CLEAR_IN] = 1'b1; // see RULE7
		// rc mode takes pin six for the instruction clock even with the output bit clear
		t[gpio_pkg::PIN_OSC_OUT] = fctl[gpio_pkg::FCTL_OSC_OUT] | rc; // see RULE10
		t[gpio_pkg::PIN_OSC_IN] = fctl[gpio_pkg::FCTL_OSC_IN]; // see RULE10
		return t;
	endfunction

	// register read mux; unmapped indices read as zero
	function automatic logic [7:0] read_reg(input logic [7:0] ix, input logic [7:0] pins,
		input gpio_pkg::port_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (ix)
			gpio_pkg::REG_DATA_IDX:
			begin
				v = pins; // see RULE4
			end
			gpio_pkg::REG_DIR_IDX:
			begin
				v = dir_readback(s.dir); // see RULE7
			end
			gpio_pkg::REG_ACFG_IDX:
			begin
				v = s.acfg;
			end
			gpio_pkg::REG_FCTL_IDX:
			begin
				v = s.fctl;
			end
			default:
			begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	// register write with lane zero; unmapped indices leave the state alone
	function automatic gpio_pkg::port_state_t write_reg(input gpio_pkg::port_state_t cur,
		input logic [7:0] ix, input logic [7:0] d);
		gpio_pkg::port_state_t s;
		s = cur;
		case (ix)
			gpio_pkg::REG_DATA_IDX:
			begin
				// all eight bits come from the bus, so the modify step replaces them
				s.latch = d; // see RULE4 RULE5
			end
			gpio_pkg::REG_DIR_IDX:
			begin
				s.dir = dir_readback(d); // see RULE7
			end
			gpio_pkg::REG_ACFG_IDX:
			begin
				s.acfg = d & gpio_pkg::ACFG_MASK;
			end
			gpio_pkg::REG_FCTL_IDX:
			begin
				s.fctl = d & gpio_pkg::FCTL_MASK;
			end
			default:
			begin
				s = cur;
			end
		endcase
		return s;
	endfunction

	// cold reset clears the whole latch; a warm one keeps bits 7:5
	function automatic gpio_pkg::port_state_t reset_state(input gpio_pkg::port_state_t cur,
		input logic cold);
		gpio_pkg::port_state_t s;
		s = cur;
		if (cold)
		begin
			s.latch = 8'h00;
		end
		else
		begin
			s.latch = cur.latch & ~gpio_pkg::LATCH_LOW_MASK;
		end
		// direction all ones leaves every driver off until software opts in
		s.dir = gpio_pkg::DIR_RST;
		s.acfg = gpio_pkg::ACFG_RST;
		s.fctl = gpio_pkg::FCTL_RST;
		s.ack = 1'b0;
		s.rdat = 8'h00;
		s.div = 2'h0;
		s.iclk = 1'b0;
		return s;
	endfunction

	assign idx = wb_adr_i[9:2];
	assign req = wb_cyc_i & wb_stb_i;
	assign rc_mode = st_r.fctl[gpio_pkg::FCTL_RC_MODE];
	assign fn_tmr = st_r.fctl[gpio_pkg::FCTL_TMR_CLK];
	assign fn_master_clear_in = st_r.fctl[gpio_pkg::FCTL_MASTER_CLEAR_IN];
	assign fn_osc_in = st_r.fctl[gpio_pkg::FCTL_OSC_IN];
	assign fn_osc_out = st_r.fctl[gpio_pkg::FCTL_OSC_OUT];
	// a write lands only at the edge where the master samples ack high
	assign wr_take = st_r.ack & req & wb_we_i;
	assign wr_lane = wb_sel_i[0];

	assign analog_mask = analog_decode(st_r.acfg[3:0]); // see RULE11
	assign analog_pins = {3'h0, analog_mask};

	assign taken = owned_pins(analog_mask, st_r.fctl, rc_mode); // see RULE6

	// analog pins read as zero whatever level sits on them
	assign pin_read = pad_in_i & ~analog_pins; // see RULE16

	// read data is captured at the request edge, so pins are sampled there
	assign rd_val = read_reg(idx, pin_read, st_r); // see RULE4

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.div = st_r.div + 2'h1;
		// quarter-rate clock: high for two cycles, low for two
		if (st_r.div == gpio_pkg::DIV_LAST)
		begin
			st_nxt.iclk = 1'b0;
		end
		else if (st_r.div == 2'h1)
		begin
			st_nxt.iclk = 1'b1;
		end
		// ack comes one cycle after the request; the write lands one edge later, while ack is high
		if (st_r.ack)
		begin
			st_nxt.ack = 1'b0;
			if (wr_take && wr_lane)
			begin
				st_nxt = write_reg(st_nxt, idx, wb_dat_i[7:0]);
			end
			else if (wr_take && idx == gpio_pkg::REG_DATA_IDX)
			begin
				// lane not addressed: the sampled pins are written back unchanged
				st_nxt.latch = pin_read; // see RULE5
			end
		end
		else if (req)
		begin
			st_nxt.ack = 1'b1;
			st_nxt.rdat = rd_val;
		end
		// power-on wins over a warm reset when both are raised
		if (por_i)
		begin
			st_nxt = reset_state(st_r, 1'b1); // see RULE14
		end
		else if (rst_i)
		begin
			// upper latch bits survive a warm reset
			st_nxt = reset_state(st_r, 1'b0); // see RULE14
		end
	end

	always_ff @(posedge clk_i)
	begin
		st_r <= st_nxt;
	end

	// drivers: pin six drives while rc mode or oscillator output owns it; any other pin only while its direction bit is zero and nothing owns it
	always_comb
	begin
		pad_oe_o = ~st_r.dir & ~taken; // see RULE1 RULE2 RULE3 RULE17
		pad_out_o = st_r.latch; // see RULE3
		if (rc_mode)
		begin
			pad_oe_o[gpio_pkg::PIN_OSC_OUT] = 1'b1; // see RULE12
			pad_out_o[gpio_pkg::PIN_OSC_OUT] = st_r.iclk;
		end
		else if (fn_osc_out)
		begin
			pad_oe_o[gpio_pkg::PIN_OSC_OUT] = 1'b1; // see RULE10
			pad_out_o[gpio_pkg::PIN_OSC_OUT] = osc_drive_i;
		end
	end

	// function inputs are gated so a disabled function sees a quiet level
	assign timer_zero_ext_clock_o = fn_gate(fn_tmr, pad_in_i[gpio_pkg::PIN_TMR]); // see RULE8
	assign master_clear_in_o = fn_gate(fn_master_clear_in, pad_in_i[gpio_pkg::PIN_MASTER_CLEAR_IN]); // see RULE9
	assign oscillator_input_o = fn_gate(fn_osc_in, pad_in_i[gpio_pkg::PIN_OSC_IN]); // see RULE10
	assign instr_clock_out_o = st_r.iclk;
	assign analog_sel_o = analog_mask; // see RULE11

	always_comb
	begin
		schmitt_sel_o = gpio_pkg::SCHMITT_FIXED; // see RULE8 RULE9
		schmitt_sel_o[gpio_pkg::PIN_OSC_IN] = rc_mode; // see RULE13
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = {24'h000000, st_r.rdat};
endmodule
`default_nettype wire
